//--- rtl/spm_monitor.v
// Purpose: Position window, S-curve completion delay, near target, soft limits, alarm log.
// Assumes: All inputs come from logic on core_clk; sys_rst stands for power-on.
// Notes: Each split address commits when its high half is written.
`timescale 1ns/1ps
`include "spm_map.vh"

module spm_monitor
#(
   parameter MS_CYCLES = `SPM_MS_CYCLES
)
(
   input  wire                              core_clk,
   input  wire                              sys_rst,
   input  wire                              log_init,
   input  wire signed [`SPM_HALF_W-1:0]     range_plus_low_digits,
   input  wire                              range_plus_low_wr,
   input  wire signed [`SPM_HALF_W-1:0]     range_plus_high_digits,
   input  wire                              range_plus_high_wr,
   input  wire signed [`SPM_HALF_W-1:0]     range_minus_low_digits,
   input  wire                              range_minus_low_wr,
   input  wire signed [`SPM_HALF_W-1:0]     range_minus_high_digits,
   input  wire                              range_minus_high_wr,
   input  wire signed [`SPM_HALF_W-1:0]     soft_limit_plus_low,
   input  wire                              soft_limit_plus_low_wr,
   input  wire signed [`SPM_HALF_W-1:0]     soft_limit_plus_high,
   input  wire                              soft_limit_plus_high_wr,
   input  wire signed [`SPM_HALF_W-1:0]     soft_limit_minus_low,
   input  wire                              soft_limit_minus_low_wr,
   input  wire signed [`SPM_HALF_W-1:0]     soft_limit_minus_high,
   input  wire                              soft_limit_minus_high_wr,
   input  wire [`SPM_SCURVE_W-1:0]          s_curve_time_constant,
   input  wire [`SPM_NEAR_W-1:0]            near_target_threshold,
   input  wire                              alarm_log_clear_request,
   input  wire signed [`SPM_POS_W-1:0]      current_position,
   input  wire signed [`SPM_POS_W-1:0]      target_position,
   input  wire [`SPM_POS_W-1:0]             remaining_distance,
   input  wire                              profile_done,
   input  wire                              home_return_active,
   input  wire                              alarm_event,
   input  wire [`SPM_CODE_W-1:0]            alarm_code,
   input  wire [`SPM_LOG_IDX_W-1:0]         alarm_log_rd_idx,
   output reg                               position_window_output,
   output reg                               positioning_done_flag,
   output reg                               near_target_output,
   output reg                               motor_stop,
   output reg                               servo_lock,
   output reg                               parameter_error_alarm,
   output reg                               alarm_log_clear_return,
   output wire [`SPM_CODE_W-1:0]            alarm_log_rd_code,
   output wire                              alarm_log_rd_valid
);

   // Committed halves and the staged low halves of the four split addresses.
   reg signed [`SPM_HALF_W-1:0] rp_lo_stage_q, rp_lo_q, rp_hi_q;
   reg signed [`SPM_HALF_W-1:0] rm_lo_stage_q, rm_lo_q, rm_hi_q;
   reg signed [`SPM_HALF_W-1:0] lp_lo_stage_q, lp_lo_q, lp_hi_q;
   reg signed [`SPM_HALF_W-1:0] lm_lo_stage_q, lm_lo_q, lm_hi_q;

   // Joins an upper and a lower three-digit half into one signed value.
   function signed [`SPM_POS_W-1:0] join_digits;
      input signed [`SPM_HALF_W-1:0] hi;
      input signed [`SPM_HALF_W-1:0] lo;
      reg signed [`SPM_POS_W-1:0] hi_ext;
      reg signed [`SPM_POS_W-1:0] lo_ext;
      reg signed [2*`SPM_POS_W-1:0] prod;
      begin
         hi_ext      = {{(`SPM_POS_W-`SPM_HALF_W){hi[`SPM_HALF_W-1]}}, hi};
         lo_ext      = {{(`SPM_POS_W-`SPM_HALF_W){lo[`SPM_HALF_W-1]}}, lo};
         prod        = hi_ext * `SPM_DIGIT_SCALE;
         join_digits = prod[`SPM_POS_W-1:0] + lo_ext;
      end
   endfunction

   // True when one half is positive and the other negative; zero fits either sign.
   function sign_clash;
      input signed [`SPM_HALF_W-1:0] hi;
      input signed [`SPM_HALF_W-1:0] lo;
      begin
         sign_clash = (hi < 0 && lo > 0) || (hi > 0 && lo < 0);
      end
   endfunction

   // Low half is only staged; the high write commits both so a half-updated value never acts.
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         rp_lo_stage_q <= `SPM_HALF_RESET;
         rp_lo_q       <= `SPM_HALF_RESET;
         rp_hi_q       <= `SPM_HALF_RESET;
         rm_lo_stage_q <= `SPM_HALF_RESET;
         rm_lo_q       <= `SPM_HALF_RESET;
         rm_hi_q       <= `SPM_HALF_RESET;
         lp_lo_stage_q <= `SPM_HALF_RESET;
         lp_lo_q       <= `SPM_HALF_RESET;
         lp_hi_q       <= `SPM_HALF_RESET;
         lm_lo_stage_q <= `SPM_HALF_RESET;
         lm_lo_q       <= `SPM_HALF_RESET;
         lm_hi_q       <= `SPM_HALF_RESET;
      end
      else
      begin
         if (range_plus_low_wr)
            rp_lo_stage_q <= range_plus_low_digits;
         if (range_plus_high_wr)
         begin
            rp_hi_q <= range_plus_high_digits;
            rp_lo_q <= rp_lo_stage_q;
         end
         if (range_minus_low_wr)
            rm_lo_stage_q <= range_minus_low_digits;
         if (range_minus_high_wr)
         begin
            rm_hi_q <= range_minus_high_digits;
            rm_lo_q <= rm_lo_stage_q;
         end
         if (soft_limit_plus_low_wr)
            lp_lo_stage_q <= soft_limit_plus_low;
         if (soft_limit_plus_high_wr)
         begin
            lp_hi_q <= soft_limit_plus_high;
            lp_lo_q <= lp_lo_stage_q;
         end
         if (soft_limit_minus_low_wr)
            lm_lo_stage_q <= soft_limit_minus_low;
         if (soft_limit_minus_high_wr)
         begin
            lm_hi_q <= soft_limit_minus_high;
            lm_lo_q <= lm_lo_stage_q;
         end
      end
   end

   // Combined addresses and the checks on them.
   wire signed [`SPM_POS_W-1:0] range_plus  = join_digits(rp_hi_q, rp_lo_q);
   wire signed [`SPM_POS_W-1:0] range_minus = join_digits(rm_hi_q, rm_lo_q);
   wire signed [`SPM_POS_W-1:0] limit_plus  = join_digits(lp_hi_q, lp_lo_q);
   wire signed [`SPM_POS_W-1:0] limit_minus = join_digits(lm_hi_q, lm_lo_q);
   wire range_sign_err = sign_clash(rm_hi_q, rm_lo_q) || sign_clash(rp_hi_q, rp_lo_q);
   wire limit_sign_err = sign_clash(lp_hi_q, lp_lo_q) || sign_clash(lm_hi_q, lm_lo_q);
   wire limit_order_err = limit_plus < limit_minus;
   wire limit_enabled = (limit_plus != limit_minus) && !home_return_active;
   wire limit_hit = limit_enabled && !limit_order_err &&
                    (target_position > limit_plus || target_position < limit_minus);

   // Parameter error, window, near target and limit stop outputs, all registered.
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         parameter_error_alarm  <= 1'b0;
         position_window_output <= 1'b0;
         near_target_output     <= 1'b0;
         motor_stop             <= 1'b0;
         servo_lock             <= 1'b0;
      end
      else
      begin
         parameter_error_alarm  <= range_sign_err || limit_sign_err || limit_order_err;
         position_window_output <= current_position >= range_minus &&
                                   current_position <= range_plus;
         near_target_output     <= remaining_distance <= {16'h0000, near_target_threshold};
         // Stop holds only while the command still lies outside, like a stroke end.
         motor_stop             <= limit_hit;
         servo_lock             <= limit_hit;
      end
   end

   // S-curve completion delay: whole milliseconds from a prescaler, clamped to the maximum.
   wire [`SPM_SCURVE_W-1:0] tc_ms = (s_curve_time_constant > `SPM_SCURVE_MAX_MS) ?
                                    `SPM_SCURVE_MAX_MS : s_curve_time_constant;
   reg [`SPM_MS_CNT_W-1:0] ms_cnt_q;
   reg [`SPM_SCURVE_W-1:0] ms_done_q;
   reg                     delaying_q;
   reg                     done_seen_q;
   wire ms_tick = (ms_cnt_q == MS_CYCLES - 1);

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         ms_cnt_q              <= {`SPM_MS_CNT_W{1'b0}};
         ms_done_q             <= {`SPM_SCURVE_W{1'b0}};
         delaying_q            <= 1'b0;
         done_seen_q           <= 1'b0;
         positioning_done_flag <= 1'b0;
      end
      else
      begin
         done_seen_q <= profile_done;
         if (!profile_done)
         begin
            // A new move drops completion and aborts any pending delay.
            delaying_q            <= 1'b0;
            positioning_done_flag <= 1'b0;
         end
         else if (!done_seen_q)
         begin
            ms_cnt_q   <= {`SPM_MS_CNT_W{1'b0}};
            ms_done_q  <= {`SPM_SCURVE_W{1'b0}};
            delaying_q <= (tc_ms != {`SPM_SCURVE_W{1'b0}});
            positioning_done_flag <= (tc_ms == {`SPM_SCURVE_W{1'b0}});
         end
         else if (delaying_q)
         begin
            ms_cnt_q <= ms_tick ? {`SPM_MS_CNT_W{1'b0}} : ms_cnt_q + 1'b1;
            if (ms_tick)
            begin
               ms_done_q <= ms_done_q + 1'b1;
               if (ms_done_q + 1'b1 >= tc_ms)
               begin
                  delaying_q            <= 1'b0;
                  positioning_done_flag <= 1'b1;
               end
            end
         end
      end
   end

   // Clear request is caught once after power-on; later changes wait for the next one.
   reg clear_armed_q;
   reg clear_taken_q;
   wire log_clear = clear_armed_q && !clear_taken_q;

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         clear_armed_q          <= 1'b0;
         clear_taken_q          <= 1'b0;
         alarm_log_clear_return <= 1'b0;
      end
      else
      begin
         if (!clear_taken_q && !clear_armed_q)
            clear_armed_q <= alarm_log_clear_request;
         if (clear_armed_q || !alarm_log_clear_request)
            clear_taken_q <= 1'b1;
         alarm_log_clear_return <= log_clear;
      end
   end

   // History store; a clear and an alarm in the same cycle keep the alarm out.
   spm_alarm_log u_log
   (
      .core_clk   (core_clk),
      .log_init   (log_init),
      .clear      (log_clear),
      .push       (alarm_event && !sys_rst),
      .push_code  (alarm_code),
      .rd_idx     (alarm_log_rd_idx),
      .rd_code_q  (alarm_log_rd_code),
      .rd_valid_q (alarm_log_rd_valid)
   );

endmodule

//--- include/spm_map.vh
// Purpose: Constants for the servo position limit monitor.
// Assumes: 200 MHz core clock, positions in feed-scaled micrometre units.
// Notes: Included by bare name from the design files.
//
// Overview of operation
// - Minus range halves must share one sign, else a parameter error is flagged.
// - Plus and minus range addresses bound the span of the position window output.
// - Nonzero S-curve constant smooths motion and delays positioning done by that time.
// - S-curve time constant is accepted from 0 up to 1000 ms.
// - Alarm history keeps the present alarm plus five earlier alarms.
// - After a history clear the device returns the clear request to default.
// - A new history clear request acts only after a power cycle.
// - Near target output asserts when remaining travel reaches threshold 0 to 65535.
// - Motion beyond the soft limits stops the motor and holds servo lock.
// - Soft limit checking runs from power-on but is suspended during home return.
// - Soft limit checking is off when plus limit equals minus limit.
// - Plus soft limit below minus soft limit raises the parameter error alarm.
`ifndef SPM_MAP_VH
`define SPM_MAP_VH

`define SPM_HALF_W        11
`define SPM_POS_W         32
`define SPM_DIGIT_SCALE   32'sd1000
`define SPM_HALF_RESET    11'h000
`define SPM_SCURVE_W      10
`define SPM_SCURVE_MAX_MS 10'h3E8
`define SPM_NEAR_W        16
`define SPM_CODE_W        8
`define SPM_LOG_DEPTH     6
`define SPM_LOG_IDX_W     3
`define SPM_CLK_PERIOD_NS 5
`define SPM_MS_NS         1000000
`define SPM_MS_CYCLES     (`SPM_MS_NS / `SPM_CLK_PERIOD_NS)
`define SPM_MS_CNT_W      18

`endif

//--- rtl/spm_alarm_log.v
// Purpose: Six-entry alarm history, newest entry at index 0.
// Assumes: Entries survive sys_rst; only log_init or clear empties them.
// Notes: Read data comes from a register, one cycle after the index.
`timescale 1ns/1ps
`include "spm_map.vh"

module spm_alarm_log
(
   input  wire                        core_clk,
   input  wire                        log_init,
   input  wire                        clear,
   input  wire                        push,
   input  wire [`SPM_CODE_W-1:0]      push_code,
   input  wire [`SPM_LOG_IDX_W-1:0]   rd_idx,
   output reg  [`SPM_CODE_W-1:0]      rd_code_q,
   output reg                         rd_valid_q
);

   reg [`SPM_CODE_W-1:0] code_q  [0:`SPM_LOG_DEPTH-1];
   reg [`SPM_LOG_DEPTH-1:0] valid_q;
   integer i;

   // The log is kept across sys_rst on purpose, so history counts from first power-up.
   always @(posedge core_clk)
   begin
      if (log_init || clear)
      begin
         valid_q <= {`SPM_LOG_DEPTH{1'b0}};
         for (i = 0; i < `SPM_LOG_DEPTH; i = i + 1)
            code_q[i] <= {`SPM_CODE_W{1'b0}};
      end
      else if (push)
      begin
         code_q[0]  <= push_code;
         valid_q    <= {valid_q[`SPM_LOG_DEPTH-2:0], 1'b1};
         for (i = 1; i < `SPM_LOG_DEPTH; i = i + 1)
            code_q[i] <= code_q[i-1];
      end
   end

   // Registered read; indices past the last entry read as empty.
   always @(posedge core_clk)
   begin
      if (log_init || rd_idx >= `SPM_LOG_DEPTH)
      begin
         rd_code_q  <= {`SPM_CODE_W{1'b0}};
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_code_q  <= code_q[rd_idx];
         rd_valid_q <= valid_q[rd_idx];
      end
   end

endmodule

//--- sim/spm_port_monitor_monitor.sv
// Purpose: Port level checks for the position limit monitor.
// Assumes: One clock domain; sys_rst is synchronous and active high.
// Notes: Committed limits are internal, so window and limit values are judged by the bench.
`timescale 1ns/1ps
`include "spm_map.vh"

module spm_port_monitor
#(
   parameter MS_CYCLES = `SPM_MS_CYCLES
)
(
   input wire logic                      core_clk,
   input wire logic                      sys_rst,
   input wire logic [`SPM_SCURVE_W-1:0]  s_curve_time_constant,
   input wire logic [`SPM_NEAR_W-1:0]    near_target_threshold,
   input wire logic                      alarm_log_clear_request,
   input wire logic [`SPM_POS_W-1:0]     remaining_distance,
   input wire logic                      profile_done,
   input wire logic                      home_return_active,
   input wire logic [`SPM_LOG_IDX_W-1:0] alarm_log_rd_idx,
   input wire logic                      positioning_done_flag,
   input wire logic                      near_target_output,
   input wire logic                      motor_stop,
   input wire logic                      servo_lock,
   input wire logic                      alarm_log_clear_return,
   input wire logic                      alarm_log_rd_valid
);
   // Every check runs on the core clock and rests while reset is held.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // The first edge after reset is skipped because its history still holds reset values.
   a_near_match: assert property (!$past(sys_rst) |=> near_target_output ==
      ($past(remaining_distance) <= {16'h0000, $past(near_target_threshold)})) else $error("near target mismatch");
   a_done_prompt: assert property ($rose(profile_done) && s_curve_time_constant == 10'h000
      |=> positioning_done_flag) else $error("done flag late with zero time constant");
   a_done_delayed: assert property ($rose(profile_done) && s_curve_time_constant == 10'h001
      && MS_CYCLES == 10 ##1 profile_done [*5] ##1 profile_done [*5]
      |-> !positioning_done_flag ##1 positioning_done_flag) else $error("done flag delay wrong");
   a_done_drops: assert property (!profile_done |=> !positioning_done_flag)
      else $error("done flag without profile done");
   a_stop_lock: assert property (motor_stop == servo_lock)
      else $error("stop and servo lock differ");
   a_home_free: assert property (home_return_active |=> !motor_stop)
      else $error("limit stop during home return");
   a_clear_pulse: assert property (alarm_log_clear_return |=> !alarm_log_clear_return)
      else $error("clear return longer than one cycle");
   a_clear_after: assert property ($fell(sys_rst) && alarm_log_clear_request
      |-> ##[1:3] alarm_log_clear_return) else $error("clear return missing");
   a_log_depth: assert property (alarm_log_rd_idx >= 3'h6 |=> !alarm_log_rd_valid)
      else $error("log entry beyond six");

   c_done: cover property ($rose(positioning_done_flag));
   c_stop: cover property ($rose(motor_stop));
   c_clear: cover property (alarm_log_clear_return);
endmodule

bind spm_monitor spm_port_monitor #(.MS_CYCLES(MS_CYCLES)) u_spm_port_monitor (.core_clk(core_clk),
   .sys_rst(sys_rst), .s_curve_time_constant(s_curve_time_constant), .near_target_threshold(near_target_threshold),
   .alarm_log_clear_request(alarm_log_clear_request), .remaining_distance(remaining_distance),
   .profile_done(profile_done), .home_return_active(home_return_active), .alarm_log_rd_idx(alarm_log_rd_idx),
   .positioning_done_flag(positioning_done_flag), .near_target_output(near_target_output),
   .motor_stop(motor_stop), .servo_lock(servo_lock), .alarm_log_clear_return(alarm_log_clear_return),
   .alarm_log_rd_valid(alarm_log_rd_valid));

//--- sim/spm_host_model.sv
// Purpose: Host controller that writes split addresses into the monitor.
// Assumes: Writes are driven at the falling edge; sel 0..3 is range plus, range minus, limit plus, limit minus.
// Notes: Idle digit lines show the inverse of the last value, so stale levels never pass as data.
`timescale 1ns/1ps

module spm_host_model
(
   input  wire logic          core_clk,
   output logic signed [10:0] lo,
   output logic signed [10:0] hi,
   output logic        [3:0]  lo_wr,
   output logic        [3:0]  hi_wr
);
   initial
   begin
      lo = 11'h000;
      hi = 11'h000;
      lo_wr = 4'h0;
      hi_wr = 4'h0;
   end

   // Splitting by truncation keeps both halves on the sign of the whole value.
   task automatic put(input int sel, input int val, input int gap);
      put_raw(sel, val / 1000, val % 1000, gap);
   endtask

   // Low half always goes first; gap lets the host answer slowly between halves.
   task automatic put_raw(input int sel, input int h, input int l, input int gap);
      @(negedge core_clk);
      lo = l[10:0];
      lo_wr[sel] = 1'b1;
      @(negedge core_clk);
      lo_wr[sel] = 1'b0;
      repeat (gap) @(negedge core_clk);
      hi = h[10:0];
      hi_wr[sel] = 1'b1;
      @(negedge core_clk);
      hi_wr[sel] = 1'b0;
      lo = ~lo;
      hi = ~hi;
   endtask
endmodule

//--- sim/spm_monitor_bench.sv
// Purpose: Self-checking bench for the position limit monitor.
// Assumes: MS_CYCLES is 10, so one millisecond of time constant is 10 cycles.
// Notes: Outputs are sampled at the falling edge after the edge that updates them.
`timescale 1ns/1ps

module spm_monitor_bench;
   logic               clk, rst, init, clr, pd, home, ev, win, done, near, stop, lock, perr, cret, rval;
   logic signed [10:0] lo, hi;
   logic        [3:0]  lw, hw;
   logic        [9:0]  tc;
   logic        [15:0] thr;
   logic signed [31:0] pos, tgt;
   logic        [31:0] rem;
   logic        [7:0]  code, rcode;
   logic        [2:0]  idx;
   int                 error_cnt = 0;
   int                 n_compared = 0;

   spm_host_model u_spm_host_model (.core_clk(clk), .lo(lo), .hi(hi), .lo_wr(lw), .hi_wr(hw));
   spm_monitor #(.MS_CYCLES(10)) u_spm_monitor (.core_clk(clk), .sys_rst(rst), .log_init(init),
      .range_plus_low_digits(lo), .range_plus_low_wr(lw[0]), .range_plus_high_digits(hi), .range_plus_high_wr(hw[0]),
      .range_minus_low_digits(lo), .range_minus_low_wr(lw[1]), .range_minus_high_digits(hi),
      .range_minus_high_wr(hw[1]), .soft_limit_plus_low(lo), .soft_limit_plus_low_wr(lw[2]),
      .soft_limit_plus_high(hi), .soft_limit_plus_high_wr(hw[2]), .soft_limit_minus_low(lo),
      .soft_limit_minus_low_wr(lw[3]), .soft_limit_minus_high(hi), .soft_limit_minus_high_wr(hw[3]),
      .s_curve_time_constant(tc), .near_target_threshold(thr), .alarm_log_clear_request(clr),
      .current_position(pos), .target_position(tgt), .remaining_distance(rem), .profile_done(pd),
      .home_return_active(home), .alarm_event(ev), .alarm_code(code), .alarm_log_rd_idx(idx),
      .position_window_output(win), .positioning_done_flag(done), .near_target_output(near), .motor_stop(stop),
      .servo_lock(lock), .parameter_error_alarm(perr), .alarm_log_clear_return(cret), .alarm_log_rd_code(rcode),
      .alarm_log_rd_valid(rval));

   // Free running 200 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Case inequality keeps an unknown output from passing as a match.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Both range ends are probed on and one unit past the boundary.
   task automatic t_window;
      int   pv[5] = '{2500, 2501, -1200, -1201, 0};
      logic wv[5] = '{1, 0, 1, 0, 1};
      u_spm_host_model.put(0, 2500, 0);
      u_spm_host_model.put(1, -1200, 3);
      foreach (pv[i])
      begin
         pos = pv[i];
         tick(2);
         chk("window", wv[i], win);
      end
      u_spm_host_model.put_raw(1, -1, 5, 0);
      tick(2);
      chk("sign clash", 1, perr);
      u_spm_host_model.put(1, -1200, 0);
      tick(2);
      chk("sign restored", 0, perr);
      $display("test window done");
   endtask

   task automatic t_limits;
      int   tv[4] = '{1001, -1001, 1000, 1001};
      logic hv[4] = '{0, 0, 0, 1};
      logic sv[4] = '{1, 1, 0, 0};
      u_spm_host_model.put(2, 1000, 1);
      u_spm_host_model.put(3, -1000, 0);
      foreach (tv[i])
      begin
         tgt = tv[i];
         home = hv[i];
         tick(2);
         chk("stop", sv[i], stop);
         chk("lock", sv[i], lock);
      end
      home = 1'b0;
      u_spm_host_model.put(3, 1000, 0);
      tick(2);
      chk("equal limits", 0, stop);
      u_spm_host_model.put(3, 2000, 0);
      tick(2);
      chk("order error", 1, perr);
      u_spm_host_model.put(3, -1000, 0);
      tgt = 0;
      tick(2);
      chk("order cleared", 0, perr);
      $display("test limits done");
   endtask

   task automatic t_near;
      int   rv[6] = '{100, 101, 0, 1, 65535, 65536};
      int   hv[6] = '{100, 100, 0, 0, 65535, 65535};
      logic ev2[6] = '{1, 0, 1, 0, 1, 0};
      foreach (rv[i])
      begin
         rem = rv[i];
         thr = hv[i][15:0];
         tick(2);
         chk("near", ev2[i], near);
      end
      $display("test near done");
   endtask

   // Largest accepted constant is run in full, and an oversized one must act as that largest value.
   // The flag rises at the edge that closes tc times ten cycles after the first edge seeing profile done.
   task automatic t_scurve;
      int tv[4] = '{0, 1, 1000, 1023};
      int k;
      foreach (tv[i])
      begin
         tc = tv[i][9:0];
         k = ((tv[i] > 1000) ? 1000 : tv[i]) * 10;
         pd = 1'b1;
         tick(k);
         chk("done early", 0, done);
         tick(1);
         chk("done on time", 1, done);
         pd = 1'b0;
         tick(2);
         chk("done dropped", 0, done);
      end
      $display("test scurve done");
   endtask

   task automatic t_log;
      for (int i = 1; i <= 7; i++)
      begin
         ev = 1'b1;
         code = 8'h10 + i[7:0];
         tick(1);
      end
      ev = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         idx = i[2:0];
         tick(1);
         chk("log valid", i < 6, rval);
         if (i < 6) chk("log code", 8'h17 - i[7:0], rcode);
      end
      $display("test log done");
   endtask

   // A request raised after reset must not clear until the next power-on.
   task automatic t_clear;
      int seen = 0;
      idx = 3'h0;
      clr = 1'b1;
      tick(3);
      chk("request after power-on", 1, rval);
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      repeat (4)
      begin
         tick(1);
         if (cret === 1'b1) seen++;
      end
      chk("clear pulses", 1, seen);
      idx = 3'h0;
      tick(1);
      chk("log emptied", 0, rval);
      ev = 1'b1;
      code = 8'h2A;
      tick(1);
      ev = 1'b0;
      tick(3);
      chk("late request ignored", 1, rval);
      chk("kept code", 8'h2A, rcode);
      $display("test clear done");
   endtask

   initial
   begin
      {rst, init} = 2'h3;
      {clr, pd, home, ev} = 4'h0;
      {tc, thr, pos, tgt, rem, code, idx} = '0;
      tick(16);
      {rst, init} = 2'h0;
      t_window();
      t_limits();
      t_near();
      t_scurve();
      t_log();
      t_clear();
      finish_test();
   end
endmodule
